// ---- hdl/pcg_defs.svh ----
// Purpose: constants of the peripheral clock gating block
// Assumes: byte addresses on the register bus, 32-bit aligned words
// Notes:   offsets, field positions, masks, reset values and the unit count only
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH

`define PCG_OFF_RUN0       9'h100
`define PCG_OFF_RUN1       9'h104
`define PCG_OFF_SLEEP0     9'h110
`define PCG_OFF_SLEEP1     9'h114
`define PCG_OFF_DEEP0      9'h120
`define PCG_OFF_DEEP1      9'h124

`define PCG_MASK_GRP0      32'h0011_0F08
`define PCG_MASK_GRP1      32'h0107_0113
`define PCG_RESET_GATE     32'h0000_0000

`define PCG_BIT_PWM        20
`define PCG_BIT_CONV       16
`define PCG_BIT_WDOG       3
`define PCG_RATE_HI        11
`define PCG_RATE_LO        8
`define PCG_BIT_CMP_ZERO   24
`define PCG_BIT_TMR2       18
`define PCG_BIT_TMR1       17
`define PCG_BIT_TMR0       16
`define PCG_BIT_QDEC       8
`define PCG_BIT_SSER       4
`define PCG_BIT_SER1       1
`define PCG_BIT_SER0       0

`define PCG_NUM_UNITS      11

`endif

// ---- hdl/pcg_pkg.sv ----
// Purpose: types of the peripheral clock gating block
// Assumes: constants come from pcg_defs.svh
// Notes:   unit index order matches the enable vector
package pcg_pkg;

  typedef enum logic [1:0]
  {
    PCG_RUN   = 2'h0,
    PCG_SLEEP = 2'h1,
    PCG_DEEP  = 2'h3
  } pcg_mode_t;

  typedef enum logic [3:0]
  {
    PCG_RATE_125K = 4'h0,
    PCG_RATE_250K = 4'h1,
    PCG_RATE_500K = 4'h2
  } pcg_rate_t;

  typedef enum logic [1:0]
  {
    PCG_RESP_OKAY   = 2'h0,
    PCG_RESP_SLVERR = 2'h2
  } pcg_resp_t;

  typedef enum logic [3:0]
  {
    PCG_U_PWM   = 4'h0,
    PCG_U_CONV  = 4'h1,
    PCG_U_WDOG  = 4'h2,
    PCG_U_CMP_ZERO = 4'h3,
    PCG_U_TMR0  = 4'h4,
    PCG_U_TMR1  = 4'h5,
    PCG_U_TMR2  = 4'h6,
    PCG_U_QDEC  = 4'h7,
    PCG_U_SSER  = 4'h8,
    PCG_U_SER0  = 4'h9,
    PCG_U_SER1  = 4'hA
  } pcg_unit_t;

endpackage : pcg_pkg

// ---- hdl/pcg_clk_gate.sv ----
// Purpose: enable flops for the per-unit clock gates
// Assumes: downstream cell ANDs the enable with the high clock phase
// Notes:   falling-edge capture keeps every enable stable while clock is high
`timescale 1ns/100ps
`default_nettype none
module pcg_clk_gate
  import pcg_pkg::*;
#(
  parameter int N = 11
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] en_req,
  output var  logic [N-1:0] en
);

  // ------------------------------------------------------------
  // Enable capture
  // ------------------------------------------------------------
  // Changing on the falling edge means an AND gate never slices a pulse
  always_ff @(negedge clk)
  begin
    if (!rst_n)
    begin
      en <= '0;
    end
    else
    begin
      en <= en_req;
    end
  end

endmodule : pcg_clk_gate
`default_nettype wire

// ---- hdl/pcg_fault_check.sv ----
// Purpose: bus fault for accesses to unclocked peripheral units
// Assumes: one access strobe per cycle with the unit index beside it
// Notes:   indices past the last gated unit are never faulted
`timescale 1ns/100ps
`default_nettype none
module pcg_fault_check
  import pcg_pkg::*;
#(
  parameter int N = 11
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         access,
  input  wire logic [3:0]   sel,
  input  wire logic [N-1:0] en,
  output var  logic         fault
);

  logic gated_off;

  always_comb
  begin
    gated_off = 1'b0;
    if (sel < 4'(N))
    begin
      gated_off = !en[sel];
    end
  end

  // ------------------------------------------------------------
  // Fault strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fault <= 1'b0;
    end
    else
    begin
      fault <= access && gated_off;
    end
  end

endmodule : pcg_fault_check
`default_nettype wire

// ---- hdl/pcg_top.sv ----
// Purpose: peripheral clock gating registers, mode copy select, unit enables
// Assumes: Avalon-MM slave with byte addresses; power mode given as levels
// Notes:   one wait state on every access; reserved bits read as zero
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_defs.svh"
module pcg_top
  import pcg_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [8:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output var  logic [31:0] AVS_READDATA,
  output var  logic        AVS_WAITREQUEST,
  output var  logic [1:0]  AVS_RESPONSE,
  input  wire logic        AUTO_GATING_SELECT,
  input  wire logic        SLEEP_MODE,
  input  wire logic        DEEP_SLEEP_MODE,
  input  wire logic        PERIPH_ACCESS,
  input  wire logic [3:0]  PERIPH_SEL,
  output var  logic        PERIPH_FAULT,
  output var  logic [10:0] UNIT_CLK_EN,
  output var  logic [3:0]  CONV_MAX_RATE,
  output var  logic [1:0]  POWER_MODE
);

  // ------------------------------------------------------------
  // Register map tables
  // ------------------------------------------------------------
  localparam logic [8:0]  COPY_OFF [3][2] = '{
    '{`PCG_OFF_RUN0,   `PCG_OFF_RUN1},
    '{`PCG_OFF_SLEEP0, `PCG_OFF_SLEEP1},
    '{`PCG_OFF_DEEP0,  `PCG_OFF_DEEP1}
  };
  localparam logic [31:0] GRP_MASK [2] = '{`PCG_MASK_GRP0, `PCG_MASK_GRP1};

  // Unit order follows pcg_unit_t
  localparam int UNIT_GRP [`PCG_NUM_UNITS] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1};
  localparam int UNIT_BIT [`PCG_NUM_UNITS] = '{
    `PCG_BIT_PWM, `PCG_BIT_CONV, `PCG_BIT_WDOG, `PCG_BIT_CMP_ZERO,
    `PCG_BIT_TMR0, `PCG_BIT_TMR1, `PCG_BIT_TMR2, `PCG_BIT_QDEC,
    `PCG_BIT_SSER, `PCG_BIT_SER0, `PCG_BIT_SER1
  };

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [31:0]            gate_reg [3][2];
  logic [31:0]            active   [2];
  logic [31:0]            be_mask;
  logic [31:0]            rd_val;
  logic                   rd_hit;
  logic                   req;
  logic                   accept;
  logic [10:0]            unit_req;
  logic [10:0]            unit_en;
  logic                   fault;
  pcg_mode_t              mode_q;
  pcg_mode_t              next_mode;
  int                     mode_idx;
  logic [10:0]            en_at_rise;

  assign req    = AVS_READ || AVS_WRITE;
  assign accept = req && !AVS_WAITREQUEST;

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  // Waitrequest idles high and drops for one cycle per request
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      AVS_WAITREQUEST <= 1'b1;
    end
    else
    begin
      AVS_WAITREQUEST <= !(req && AVS_WAITREQUEST);
    end
  end

  // ------------------------------------------------------------
  // Address decode and read mux
  // ------------------------------------------------------------
  always_comb
  begin
    rd_hit = 1'b0;
    rd_val = '0;
    for (int m = 0; m < 3; m++)
    begin
      for (int g = 0; g < 2; g++)
      begin
        if (AVS_ADDRESS[8:2] == COPY_OFF[m][g][8:2])
        begin
          rd_hit = 1'b1;
          rd_val = gate_reg[m][g] & GRP_MASK[g];
        end
      end
    end
  end

  always_comb
  begin
    be_mask = '0;
    for (int b = 0; b < 4; b++)
    begin
      be_mask[8*b +: 8] = {8{AVS_BYTEENABLE[b]}};
    end
  end

  // Data loaded on the waiting edge so it already stands at the accept edge
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      AVS_READDATA <= '0;
      AVS_RESPONSE <= PCG_RESP_OKAY;
    end
    else if (req && AVS_WAITREQUEST)
    begin
      AVS_READDATA <= AVS_READ ? rd_val : 32'h0000_0000;
      AVS_RESPONSE <= rd_hit ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
    end
  end

  // ------------------------------------------------------------
  // Gating register copies
  // ------------------------------------------------------------
  // Only documented fields are stored, so reserved bits cannot be changed
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      for (int m = 0; m < 3; m++)
      begin
        for (int g = 0; g < 2; g++)
        begin
          gate_reg[m][g] <= `PCG_RESET_GATE;
        end
      end
    end
    else if (accept && AVS_WRITE)
    begin
      for (int m = 0; m < 3; m++)
      begin
        for (int g = 0; g < 2; g++)
        begin
          if (AVS_ADDRESS[8:2] == COPY_OFF[m][g][8:2])
          begin
            gate_reg[m][g] <= (gate_reg[m][g] & ~(GRP_MASK[g] & be_mask))
                            | (AVS_WRITEDATA & GRP_MASK[g] & be_mask);
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Power mode tracking
  // ------------------------------------------------------------
  // Without automatic gating the run copy rules in every mode
  always_comb
  begin
    next_mode = PCG_RUN;
    if (AUTO_GATING_SELECT)
    begin
      if (DEEP_SLEEP_MODE)
      begin
        next_mode = PCG_DEEP;
      end
      else if (SLEEP_MODE)
      begin
        next_mode = PCG_SLEEP;
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      mode_q <= PCG_RUN;
    end
    else
    begin
      mode_q <= next_mode;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      POWER_MODE <= PCG_RUN;
    end
    else
    begin
      POWER_MODE <= next_mode;
    end
  end

  always_comb
  begin
    case (mode_q)
      PCG_RUN:   mode_idx = 0;
      PCG_SLEEP: mode_idx = 1;
      PCG_DEEP:  mode_idx = 2;
      default:   mode_idx = 0;
    endcase
  end

  assign active[0] = gate_reg[mode_idx][0];
  assign active[1] = gate_reg[mode_idx][1];

  // ------------------------------------------------------------
  // Unit enable mapping
  // ------------------------------------------------------------
  // Covers PWM, converter, watchdog, comparator, timers, decoder, serial
  genvar u;
  generate
    for (u = 0; u < `PCG_NUM_UNITS; u++)
    begin : g_unit
      assign unit_req[u] = active[UNIT_GRP[u]][UNIT_BIT[u]];
    end
  endgenerate

  pcg_clk_gate #(
    .N      (`PCG_NUM_UNITS)
  ) u_gate (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .en_req (unit_req),
    .en     (unit_en)
  );

  assign UNIT_CLK_EN = unit_en;

  // ------------------------------------------------------------
  // Converter rate limit
  // ------------------------------------------------------------
  // Codes above 500K pass through unchanged; the converter treats them
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      CONV_MAX_RATE <= PCG_RATE_125K;
    end
    else
    begin
      CONV_MAX_RATE <= active[0][`PCG_RATE_HI:`PCG_RATE_LO];
    end
  end

  // ------------------------------------------------------------
  // Peripheral bus fault
  // ------------------------------------------------------------
  pcg_fault_check #(
    .N      (`PCG_NUM_UNITS)
  ) u_fault (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .access (PERIPH_ACCESS),
    .sel    (PERIPH_SEL),
    .en     (unit_en),
    .fault  (fault)
  );

  assign PERIPH_FAULT = fault;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_wait_one_cycle: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (req && AVS_WAITREQUEST) |=> (!AVS_WAITREQUEST ##1 AVS_WAITREQUEST))
    else $error("waitrequest did not drop for exactly one cycle");

  a_reset_clear: assert property (
    @(posedge MCLK)
    !RST_N |=> (gate_reg[0][0] == 32'h0 && gate_reg[2][1] == 32'h0
                && CONV_MAX_RATE == 4'h0))
    else $error("gating state not cleared by reset");

  a_reserved_zero: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (accept && AVS_READ && AVS_ADDRESS == `PCG_OFF_RUN0)
      |-> ((AVS_READDATA & ~`PCG_MASK_GRP0) == 32'h0))
    else $error("reserved bits of group 0 read nonzero");

  a_write_stored: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (accept && AVS_WRITE && AVS_ADDRESS == `PCG_OFF_DEEP1
     && AVS_BYTEENABLE == 4'hF)
      |=> (gate_reg[2][1] == ($past(AVS_WRITEDATA) & `PCG_MASK_GRP1)))
    else $error("deep sleep group 1 write not stored");

  a_run_without_auto: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    !AUTO_GATING_SELECT |=> (mode_q == PCG_RUN && active[1] == gate_reg[0][1]))
    else $error("sleep copy used without automatic gating");

  a_deep_select: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (AUTO_GATING_SELECT && DEEP_SLEEP_MODE) |=> (active[0] == gate_reg[2][0]))
    else $error("deep sleep copy not selected");

  a_enable_follow: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    $past(RST_N) |-> (UNIT_CLK_EN[0] == active[0][`PCG_BIT_PWM]
                      && UNIT_CLK_EN[10] == active[1][`PCG_BIT_SER1]))
    else $error("unit enable does not follow the active copy");

  // Enable as it stood at the last rise, compared again at the fall
  always_ff @(posedge MCLK)
  begin
    en_at_rise <= UNIT_CLK_EN;
  end

  a_enable_high_phase: assert property (
    @(negedge MCLK) disable iff (!RST_N)
    UNIT_CLK_EN == en_at_rise)
    else $error("unit enable moved during the clock high phase");

  a_rate_follow: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    1'b1 |=> (CONV_MAX_RATE == $past(active[0][11:8])))
    else $error("converter rate does not track group 0");

  a_fault_gated: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (PERIPH_ACCESS && PERIPH_SEL < 4'hB && !UNIT_CLK_EN[PERIPH_SEL])
      |=> PERIPH_FAULT)
    else $error("access to unclocked unit did not fault");

  a_no_fault_clocked: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    !(PERIPH_ACCESS && PERIPH_SEL < 4'hB && !UNIT_CLK_EN[PERIPH_SEL])
      |=> !PERIPH_FAULT)
    else $error("fault raised for a clocked unit");

  a_unmapped_error: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (accept && !rd_hit) |-> (AVS_RESPONSE == PCG_RESP_SLVERR))
    else $error("unmapped access answered okay");

  c_write_run0: cover property (
    @(posedge MCLK) disable iff (!RST_N)
    accept && AVS_WRITE && AVS_ADDRESS == `PCG_OFF_RUN0);

  c_sleep_copy: cover property (
    @(posedge MCLK) disable iff (!RST_N)
    mode_q == PCG_SLEEP && unit_req != 11'h0);

  c_deep_copy: cover property (
    @(posedge MCLK) disable iff (!RST_N)
    mode_q == PCG_DEEP ##1 mode_q == PCG_RUN);

  c_fault: cover property (
    @(posedge MCLK) disable iff (!RST_N)
    PERIPH_FAULT);

endmodule : pcg_top
`default_nettype wire

// ---- verification/pcg_tb.sv ----
// Purpose: self-checking bench for the peripheral clock gating block
// Assumes: Avalon-MM master with waitrequest, one clock, synchronous reset
// Notes:   bus outputs sampled at the falling edge, i.e. as seen at the next rise
`timescale 1ns/100ps
`default_nettype none
`include "pcg_defs.svh"
module tb
  import pcg_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [8:0]  address = 9'h000;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic [31:0] readdata;
  logic        waitreq;
  logic [1:0]  resp;
  logic        auto_sel = 1'b0;
  logic        sleep = 1'b0;
  logic        deep = 1'b0;
  logic        acc = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic        fault;
  logic [10:0] unit_en;
  logic [3:0]  rate;
  logic [1:0]  pmode;
  logic        wait_s;
  logic [31:0] rdata_s;
  logic [1:0]  resp_s;
  int          num_errors = 0;
  int          cmp_count = 0;

  pcg_top dut_u (.MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(address), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(readdata),
    .AVS_WAITREQUEST(waitreq), .AVS_RESPONSE(resp), .AUTO_GATING_SELECT(auto_sel),
    .SLEEP_MODE(sleep), .DEEP_SLEEP_MODE(deep), .PERIPH_ACCESS(acc), .PERIPH_SEL(sel),
    .PERIPH_FAULT(fault), .UNIT_CLK_EN(unit_en), .CONV_MAX_RATE(rate), .POWER_MODE(pmode));

  // ----------------------------------------
  // Clock and bus sampling
  // ----------------------------------------
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  // Registered outputs are stable here, so no race with the rising edge
  always @(negedge mclk)
  begin
    wait_s  = waitreq;
    rdata_s = readdata;
    resp_s  = resp;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q, output logic [1:0] r);
    @(posedge mclk);
    rd      <= ~w;
    wr      <= w;
    address <= a;
    wdata   <= d;
    be      <= b;
    do
    begin
      @(posedge mclk);
    end
    while (wait_s !== 1'b0);
    q = rdata_s;
    r = resp_s;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wr32(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, a, d, 4'hF, q, r);
  endtask : wr32

  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, a, 32'h0, 4'hF, q, r);
    check(q, exp);
    check(32'(r), 32'(PCG_RESP_OKAY));
  endtask : rd_chk

  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask : settle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [8:0] offs [6] = '{9'h100, 9'h104, 9'h110, 9'h114, 9'h120, 9'h124};
    foreach (offs[i])
      rd_chk(offs[i], 32'h0);
    check(32'(unit_en), 32'h0);
    check(32'(rate), 32'h0);
    check(32'(pmode), 32'h0);
  endtask : t_reset

  // Reserved bits must not stick; byte lanes mask the write
  task automatic t_mask();
    logic [31:0] q;
    logic [1:0]  r;
    wr32(9'h100, 32'hFFFF_FFFF);
    wr32(9'h104, 32'hFFFF_FFFF);
    rd_chk(9'h100, 32'h0011_0F08);
    rd_chk(9'h104, 32'h0107_0113);
    settle();
    check(32'(unit_en), 32'h7FF);
    check(32'(rate), 32'hF);
    wr32(9'h104, 32'h0);
    bus(1'b1, 9'h104, 32'hFFFF_FFFF, 4'h1, q, r);
    rd_chk(9'h104, 32'h0000_0013);
    wr32(9'h100, 32'h0);
    wr32(9'h104, 32'h0);
  endtask : t_mask

  // One bit at a time; unit index i must follow its documented bit
  task automatic t_bits();
    int          bits [11] = '{20, 16, 3, 24, 16, 17, 18, 8, 4, 0, 1};
    logic [10:0] grp1 = 11'b111_1111_1000;
    logic [31:0] v;
    for (int i = 0; i < 11; i++)
    begin
      v = 32'h1 << bits[i];
      wr32(9'h100, grp1[i] ? 32'h0 : v);
      wr32(9'h104, grp1[i] ? v : 32'h0);
      settle();
      check(32'(unit_en), 32'h1 << i);
    end
    wr32(9'h104, 32'h0);
    settle();
    check(32'(unit_en), 32'h0);
  endtask : t_bits

  task automatic t_rate();
    for (int c = 0; c < 3; c++)
    begin
      wr32(9'h100, 32'(c) << 8);
      settle();
      check(32'(rate), 32'(c));
    end
  endtask : t_rate

  task automatic t_modes();
    wr32(9'h100, 32'h0010_0000);
    wr32(9'h104, 32'h0000_0001);
    wr32(9'h110, 32'h0001_0000);
    wr32(9'h114, 32'h0000_0002);
    wr32(9'h120, 32'h0000_0208);
    wr32(9'h124, 32'h0000_0010);
    sleep <= 1'b1;
    settle();
    check(32'(unit_en), 32'h201);
    check(32'(pmode), 32'h0);
    auto_sel <= 1'b1;
    settle();
    check(32'(unit_en), 32'h402);
    check(32'(pmode), 32'h1);
    deep <= 1'b1;
    settle();
    check(32'(unit_en), 32'h104);
    check(32'(rate), 32'h2);
    check(32'(pmode), 32'h3);
    sleep <= 1'b0;
    deep  <= 1'b0;
    settle();
    check(32'(unit_en), 32'h201);
    auto_sel <= 1'b0;
  endtask : t_modes

  // Back-to-back strobes over every index; only timer one is clocked
  task automatic t_fault();
    logic exp;
    wr32(9'h100, 32'h0);
    wr32(9'h104, 32'h0002_0000);
    settle();
    for (int i = 0; i <= 16; i++)
    begin
      @(posedge mclk);
      acc <= (i < 16);
      sel <= 4'(i);
      @(negedge mclk);
      exp = (i > 0) && (i - 1 < 11) && (i - 1 != 5);
      check(32'(fault), 32'(exp));
    end
  endtask : t_fault

  task automatic t_unmapped();
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, 9'h108, 32'hFFFF_FFFF, 4'hF, q, r);
    check(32'(r), 32'(PCG_RESP_SLVERR));
    bus(1'b0, 9'h130, 32'h0, 4'hF, q, r);
    check(q, 32'h0);
    check(32'(r), 32'(PCG_RESP_SLVERR));
    rd_chk(9'h104, 32'h0002_0000);
  endtask : t_unmapped

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_mask();
    t_bits();
    t_rate();
    t_modes();
    t_fault();
    t_unmapped();
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
